// >>> common/btst_pkg.sv
// Shared constants and types of the bit error-rate tester
`default_nettype none
package btst_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] REG_ALT_RATE   = 8'hdb;
	localparam logic [7:0] REG_REP0       = 8'hdc;
	localparam logic [7:0] REG_REP1       = 8'hdd;
	localparam logic [7:0] REG_REP2       = 8'hde;
	localparam logic [7:0] REG_REP3       = 8'hdf;
	localparam logic [7:0] REG_CTRL1      = 8'he0;
	localparam logic [7:0] REG_CTRL2      = 8'he1;
	localparam logic [7:0] REG_BITS0      = 8'he3;
	localparam logic [7:0] REG_BITS1      = 8'he4;
	localparam logic [7:0] REG_BITS2      = 8'he5;
	localparam logic [7:0] REG_BITS3      = 8'he6;
	localparam logic [7:0] REG_ERR0       = 8'he7;
	localparam logic [7:0] REG_ERR1       = 8'he8;
	localparam logic [7:0] REG_ERR2       = 8'he9;
	localparam logic [7:0] REG_IFC        = 8'hea;
	localparam logic [7:0] REG_RATE       = 8'heb;
	localparam logic [7:0] REG_QUOTA_LO   = 8'hec;
	localparam logic [7:0] REG_QUOTA_HI   = 8'hed;
	localparam logic [7:0] REG_REMAIN_LO  = 8'hee;
	localparam logic [7:0] REG_REMAIN_HI  = 8'hef;
	localparam logic [7:0] REG_RESET_VAL  = 8'h00;
	// First control register fields
	localparam int CTRL1_LOAD    = 7;
	localparam int CTRL1_TXFLIP  = 6;
	localparam int CTRL1_RXFLIP  = 5;
	localparam int CTRL1_PAT_LSB = 2;
	localparam int CTRL1_LATCH   = 1;
	localparam int CTRL1_REALIGN = 0;
	// Second control register fields
	localparam int CTRL2_AUTO_LSB = 5;
	localparam int CTRL2_SHOT     = 4;
	localparam int CTRL2_RLEN_LSB = 0;
	// Interface control fields
	localparam int IFC_RXFBIT = 6;
	localparam int IFC_KICK   = 4;
	localparam int IFC_TXFBIT = 3;
	localparam int IFC_DIR    = 1;
	localparam int IFC_EN     = 0;
	// Fault rate control fields
	localparam int RATE_COMMIT    = 7;
	localparam int RATE_CONST     = 4;
	localparam int RATE_RATIO_LSB = 0;
	// Pattern choice codes
	localparam logic [2:0] PAT_P7   = 3'h0;
	localparam logic [2:0] PAT_P11  = 3'h1;
	localparam logic [2:0] PAT_P15  = 3'h2;
	localparam logic [2:0] PAT_QRSS = 3'h3;
	localparam logic [2:0] PAT_REP  = 3'h4;
	localparam logic [2:0] PAT_ALT  = 3'h5;
	localparam logic [2:0] PAT_DALY = 3'h6;
	localparam logic [2:0] PAT_P9   = 3'h7;
	// Sequence constants
	localparam logic [4:0]  REP_LAST_BASE = 5'h10;
	localparam logic [5:0]  DALY_LAST_OCT = 6'h36;
	localparam int          QRSS_RUN      = 14;
	localparam logic [19:0] LFSR_SEED     = 20'h0_0001;
	localparam logic [5:0]  LOCK_RUN_LAST = 6'h1f;
	// Receive synchroniser states
	typedef enum logic {BTST_HUNT, BTST_LOCK} btst_sync_type;
endpackage : btst_pkg
`default_nettype wire

// >>> hw/btst_seq.sv
// Pattern sequencer shared by the generator and the checker
`default_nettype none
module btst_seq
	import btst_pkg::*;
(
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	// Pattern setup
	input  wire logic [2:0]  i_choice,
	input  wire logic [31:0] i_rep_pat,
	input  wire logic [3:0]  i_rep_len,
	input  wire logic [7:0]  i_alt_rate,
	// Sequencing
	input  wire logic        i_load,
	input  wire logic        i_align,
	input  wire logic        i_adv,
	input  wire logic        i_feed_en,
	input  wire logic        i_feed_bit,
	// Current pattern bit
	output logic             o_bit
);
	logic [19:0] lfsr;
	logic [4:0]  rep_idx;
	logic [3:0]  alt_idx;
	logic [7:0]  alt_cnt;
	logic        alt_sel;
	logic [5:0]  daly_oct;
	logic [2:0]  daly_bit;
	logic        fb;
	logic [4:0]  rep_last;
	logic [7:0]  daly_byte;

	// Feedback taps per pseudorandom length
	function automatic logic tap(input logic [2:0] c, input logic [19:0] s);
		case (c)
			PAT_P7:   tap = s[6] ^ s[5];
			PAT_P9:   tap = s[8] ^ s[4];
			PAT_P11:  tap = s[10] ^ s[8];
			PAT_P15:  tap = s[14] ^ s[13];
			default:  tap = s[19] ^ s[16];
		endcase
	endfunction : tap

	// Filler octet table for the 55-octet pattern
	function automatic logic [7:0] daly_octet(input logic [5:0] o);
		daly_octet = {o, 2'b11} ^ 8'h5a;
	endfunction : daly_octet

	assign fb        = tap(i_choice, lfsr);
	assign rep_last  = {1'b0, i_rep_len} + REP_LAST_BASE; // RULE11
	assign daly_byte = daly_octet(daly_oct);

	// Select the current bit
	always_comb
	begin
		case (i_choice)
			PAT_QRSS: o_bit = fb | (lfsr[QRSS_RUN-1:0] == '0); // RULE4
			PAT_REP:  o_bit = i_rep_pat[rep_idx]; // RULE5
			PAT_ALT:  o_bit = alt_sel ? i_rep_pat[{1'b1, alt_idx}] : i_rep_pat[{1'b0, alt_idx}];
			PAT_DALY: o_bit = daly_byte[3'd7 - daly_bit]; // RULE5
			default:  o_bit = fb; // RULE3
		endcase
	end

	// Advance the pseudorandom and repetitive state
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn || i_load)
		begin
			lfsr    <= LFSR_SEED;
			rep_idx <= '0;
			alt_idx <= '0;
			alt_cnt <= '0;
			alt_sel <= 1'b0;
		end
		else if (i_adv)
		begin
			lfsr    <= {lfsr[18:0], i_feed_en ? i_feed_bit : fb};
			rep_idx <= (rep_idx == rep_last) ? 5'h00 : rep_idx + 5'h01; // RULE11
			alt_idx <= alt_idx + 4'h1;
			if (alt_idx == 4'hf)
			begin
				alt_cnt <= (alt_cnt == i_alt_rate) ? 8'h00 : alt_cnt + 8'h01; // RULE25
				if (alt_cnt == i_alt_rate)
					alt_sel <= !alt_sel;
			end
		end
	end

	// Octet position of the 55-octet pattern
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn || i_load || i_align)
		begin
			daly_oct <= '0; // RULE16
			daly_bit <= '0;
		end
		else if (i_adv)
		begin
			daly_bit <= daly_bit + 3'h1;
			if (daly_bit == 3'h7)
				daly_oct <= (daly_oct == DALY_LAST_OCT) ? 6'h00 : daly_oct + 6'h01;
		end
	end
endmodule : btst_seq
`default_nettype wire

// >>> hw/btst_top.sv
// Bit error-rate tester with APB registers
// Function
// RULE1: tx_flip_enable inverts every generated bit before sending.
// RULE2: rx_flip_enable inverts every received bit before checking.
// RULE3: Codes 000, 001, 010 pick 2^7-1, 2^11-1, 2^15-1 sequences.
// RULE4: Code 011 picks QRSS with zero run limit; 111 picks 2^9-1.
// RULE5: Codes 100, 101, 110 pick repetitive, alternating word, 55-octet patterns.
// RULE6: latch_counts rising edge copies counts to registers and clears counters.
// RULE7: force_realign rising edge drops lock and restarts synchronisation.
// RULE8: Software clears edge bits before setting them again.
// RULE9: auto_fault_rate inserts errors at ten to minus one..seven.
// RULE10: one_shot_fault rising edge inverts exactly one generated bit.
// RULE11: Repetitive length is code plus 17; ignored for pseudorandom patterns.
// RULE12: Software builds shorter patterns as multiples within 32 bits.
// RULE13: Latched bit count is 32 bits, low byte at lowest address.
// RULE14: Latched error count is 24 bits, low byte at lowest address.
// RULE15: rx_fbit_include passes the F-bit to the checker.
// RULE16: tx_octet_align_kick rising edge byte-aligns the generator.
// RULE17: tx_fbit_fill lets the generator drive the F-bit position.
// RULE18: Direction 1 sends to backplane_rx_out, receives backplane_tx_in.
// RULE19: Direction 0 sends on line pair, receives from line pair.
// RULE20: quota_commit rising edge loads the quota next cycle.
// RULE21: Ratio code selects one error per 2^(code+3) bits; constant ignores quota.
// RULE22: Without constant mode the quota limits errors; remaining count readable.
// RULE23: pattern_load_strobe rising edge reloads the generator pattern.
// RULE24: Repetitive pattern is 32 bits, low byte lowest address.
// RULE25: Alternating word uses an 8-bit word-count rate register.
// RULE26: Disabled tester drives no data and freezes counters.
`default_nettype none
module btst_top
	import btst_pkg::*;
(
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [9:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Transmit slot timing
	input  wire logic        i_tx_bit_en,
	input  wire logic        i_tx_fbit,
	// Receive slot timing and data
	input  wire logic        i_rx_bit_en,
	input  wire logic        i_rx_fbit,
	input  wire logic        i_line_rx_pair,
	input  wire logic        i_backplane_tx_in,
	// Pattern outputs
	output logic             o_line_tx_pair,
	output logic             o_line_tx_valid,
	output logic             o_backplane_rx_out,
	output logic             o_backplane_rx_valid,
	// Status
	output logic             o_sync_locked
);
	logic [7:0]  ctrl1, ctrl2, ifc, rate, alt_rate;
	logic [31:0] rep_pat;
	logic [9:0]  quota, remaining;
	logic [31:0] run_bits, bit_count;
	logic [23:0] run_errs, err_count;
	logic        prev_load, prev_latch, prev_realign, prev_shot, prev_kick, prev_commit;
	logic        load_edge, latch_edge, realign_edge, shot_edge, kick_edge, commit_edge;
	logic [7:0]  reg_idx;
	logic        wr_en, setup;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        enable, tx_step, rx_step, rx_in, rx_bit, gen_bit, chk_bit, match;
	logic        is_prbs, shot_pend, auto_hit, ratio_hit, ratio_ok, fault, tx_bit;
	logic [23:0] auto_cnt;
	logic [17:0] ratio_cnt, ratio_last;
	logic [5:0]  run_len;
	btst_sync_type sync_state;

	// Bits per automatic error less one, for the decade rate codes
	function automatic logic [23:0] auto_last(input logic [2:0] c);
		case (c)
			3'h1:    auto_last = 24'h00_0009;
			3'h2:    auto_last = 24'h00_0063;
			3'h3:    auto_last = 24'h00_03e7;
			3'h4:    auto_last = 24'h00_270f;
			3'h5:    auto_last = 24'h01_869f;
			3'h6:    auto_last = 24'h0f_423f;
			default: auto_last = 24'h98_967f;
		endcase
	endfunction : auto_last

	// APB decode
	assign reg_idx = i_paddr[9:2];
	assign setup   = i_psel && !i_penable;
	assign wr_en   = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

	// Register writes
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			ctrl1    <= REG_RESET_VAL;
			ctrl2    <= REG_RESET_VAL;
			ifc      <= REG_RESET_VAL;
			rate     <= REG_RESET_VAL;
			alt_rate <= REG_RESET_VAL;
			rep_pat  <= '0;
			quota    <= '0;
		end
		else if (wr_en)
		begin
			case (reg_idx)
				REG_ALT_RATE:  alt_rate       <= i_pwdata[7:0]; // RULE25
				REG_REP0:      rep_pat[7:0]   <= i_pwdata[7:0]; // RULE24
				REG_REP1:      rep_pat[15:8]  <= i_pwdata[7:0];
				REG_REP2:      rep_pat[23:16] <= i_pwdata[7:0];
				REG_REP3:      rep_pat[31:24] <= i_pwdata[7:0];
				REG_CTRL1:     ctrl1          <= i_pwdata[7:0];
				REG_CTRL2:     ctrl2          <= i_pwdata[7:0];
				REG_IFC:       ifc            <= i_pwdata[7:0] & 8'h5b;
				REG_RATE:      rate           <= i_pwdata[7:0] & 8'h9f;
				REG_QUOTA_LO:  quota[7:0]     <= i_pwdata[7:0];
				REG_QUOTA_HI:  quota[9:8]     <= i_pwdata[1:0];
				default:       ctrl1          <= ctrl1;
			endcase
		end
	end

	// Read data and error answer prepared in the setup phase
	always_comb
	begin
		next_prdata  = '0;
		next_pslverr = (i_paddr[1:0] != 2'b00);
		case (reg_idx)
			REG_ALT_RATE:  next_prdata[7:0] = alt_rate;
			REG_REP0:      next_prdata[7:0] = rep_pat[7:0];
			REG_REP1:      next_prdata[7:0] = rep_pat[15:8];
			REG_REP2:      next_prdata[7:0] = rep_pat[23:16];
			REG_REP3:      next_prdata[7:0] = rep_pat[31:24];
			REG_CTRL1:     next_prdata[7:0] = ctrl1;
			REG_CTRL2:     next_prdata[7:0] = ctrl2;
			REG_BITS0:     next_prdata[7:0] = bit_count[7:0]; // RULE13
			REG_BITS1:     next_prdata[7:0] = bit_count[15:8];
			REG_BITS2:     next_prdata[7:0] = bit_count[23:16];
			REG_BITS3:     next_prdata[7:0] = bit_count[31:24];
			REG_ERR0:      next_prdata[7:0] = err_count[7:0]; // RULE14
			REG_ERR1:      next_prdata[7:0] = err_count[15:8];
			REG_ERR2:      next_prdata[7:0] = err_count[23:16];
			REG_IFC:       next_prdata[7:0] = ifc;
			REG_RATE:      next_prdata[7:0] = rate;
			REG_QUOTA_LO:  next_prdata[7:0] = quota[7:0];
			REG_QUOTA_HI:  next_prdata[1:0] = quota[9:8];
			REG_REMAIN_LO: next_prdata[7:0] = remaining[7:0]; // RULE22
			REG_REMAIN_HI: next_prdata[1:0] = remaining[9:8];
			default:       next_pslverr = 1'b1;
		endcase
	end

	// One wait-free access cycle after each setup
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			o_prdata  <= '0;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end
		else
		begin
			o_pready  <= setup;
			o_pslverr <= setup && next_pslverr;
			if (setup)
				o_prdata <= next_pslverr ? 32'h0000_0000 : next_prdata;
		end
	end

	// Previous values of the edge-triggered bits
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			prev_load    <= 1'b0;
			prev_latch   <= 1'b0;
			prev_realign <= 1'b0;
			prev_shot    <= 1'b0;
			prev_kick    <= 1'b0;
			prev_commit  <= 1'b0;
		end
		else
		begin
			prev_load    <= ctrl1[CTRL1_LOAD];
			prev_latch   <= ctrl1[CTRL1_LATCH];
			prev_realign <= ctrl1[CTRL1_REALIGN];
			prev_shot    <= ctrl2[CTRL2_SHOT];
			prev_kick    <= ifc[IFC_KICK];
			prev_commit  <= rate[RATE_COMMIT];
		end
	end

	// Low-to-high detection only; a held bit acts once
	assign load_edge    = ctrl1[CTRL1_LOAD] && !prev_load; // RULE23
	assign latch_edge   = ctrl1[CTRL1_LATCH] && !prev_latch; // RULE6
	assign realign_edge = ctrl1[CTRL1_REALIGN] && !prev_realign; // RULE7
	assign shot_edge    = ctrl2[CTRL2_SHOT] && !prev_shot; // RULE10
	assign kick_edge    = ifc[IFC_KICK] && !prev_kick; // RULE16
	assign commit_edge  = rate[RATE_COMMIT] && !prev_commit; // RULE20

	// Bit slots taken by the tester
	assign enable  = ifc[IFC_EN]; // RULE26
	assign tx_step = enable && i_tx_bit_en && (!i_tx_fbit || ifc[IFC_TXFBIT]); // RULE17
	assign rx_step = enable && i_rx_bit_en && (!i_rx_fbit || ifc[IFC_RXFBIT]); // RULE15
	assign rx_in   = ifc[IFC_DIR] ? i_backplane_tx_in : i_line_rx_pair; // RULE18 RULE19
	assign rx_bit  = rx_in ^ ctrl1[CTRL1_RXFLIP]; // RULE2
	assign match   = (rx_bit == chk_bit);
	assign is_prbs = (ctrl1[4:2] == PAT_P7) || (ctrl1[4:2] == PAT_P11) ||
		(ctrl1[4:2] == PAT_P15) || (ctrl1[4:2] == PAT_QRSS) || (ctrl1[4:2] == PAT_P9);

	// Transmit pattern generator
	btst_seq u_gen (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_choice   (ctrl1[CTRL1_PAT_LSB +: 3]),
		.i_rep_pat  (rep_pat),
		.i_rep_len  (ctrl2[CTRL2_RLEN_LSB +: 4]),
		.i_alt_rate (alt_rate),
		.i_load     (load_edge),
		.i_align    (kick_edge),
		.i_adv      (tx_step),
		.i_feed_en  (1'b0),
		.i_feed_bit (1'b0),
		.o_bit      (gen_bit)
	);

	// Receive reference; hunting seeds it from the line or holds it to slip
	btst_seq u_chk (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_choice   (ctrl1[CTRL1_PAT_LSB +: 3]),
		.i_rep_pat  (rep_pat),
		.i_rep_len  (ctrl2[CTRL2_RLEN_LSB +: 4]),
		.i_alt_rate (alt_rate),
		.i_load     (realign_edge),
		.i_align    (1'b0),
		.i_adv      (rx_step && (is_prbs || match || sync_state == BTST_LOCK)),
		.i_feed_en  (is_prbs && sync_state == BTST_HUNT),
		.i_feed_bit (rx_bit),
		.o_bit      (chk_bit)
	);

	// Pattern synchroniser
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn || realign_edge) // RULE7
		begin
			sync_state <= BTST_HUNT;
			run_len    <= '0;
		end
		else if (rx_step)
		begin
			case (sync_state)
				BTST_HUNT:
				begin
					run_len <= match ? run_len + 6'h01 : 6'h00;
					if (match && run_len == LOCK_RUN_LAST)
						sync_state <= BTST_LOCK;
				end
				BTST_LOCK:  run_len <= '0;
				default:    sync_state <= BTST_HUNT;
			endcase
		end
	end

	// Running and latched counts
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			run_bits  <= '0;
			run_errs  <= '0;
			bit_count <= '0;
			err_count <= '0;
		end
		else if (latch_edge)
		begin
			bit_count <= run_bits; // RULE6
			err_count <= run_errs;
			run_bits  <= '0;
			run_errs  <= '0;
		end
		else if (rx_step) // RULE26
		begin
			run_bits <= run_bits + 32'h0000_0001;
			if (sync_state == BTST_LOCK && !match)
				run_errs <= run_errs + 24'h00_0001;
		end
	end

	// Automatic decade-rate fault timer
	assign auto_hit = (ctrl2[7:5] != 3'h0) && (auto_cnt == auto_last(ctrl2[7:5]));
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn || ctrl2[7:5] == 3'h0)
			auto_cnt <= '0;
		else if (tx_step)
			auto_cnt <= auto_hit ? 24'h00_0000 : auto_cnt + 24'h00_0001; // RULE9
	end

	// Binary-ratio fault timer with quota
	assign ratio_last = 18'((18'h0_0001 << ({1'b0, rate[3:0]} + 5'h03)) - 18'h0_0001); // RULE21
	assign ratio_ok   = (rate[3:0] != 4'h0) && (rate[RATE_CONST] || remaining != 10'h000);
	assign ratio_hit  = ratio_ok && (ratio_cnt == ratio_last);
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn || rate[3:0] == 4'h0)
			ratio_cnt <= '0;
		else if (tx_step)
			ratio_cnt <= (ratio_cnt == ratio_last) ? 18'h0_0000 : ratio_cnt + 18'h0_0001;
	end

	// Faults left to insert
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
			remaining <= '0;
		else if (commit_edge)
			remaining <= quota; // RULE20
		else if (tx_step && ratio_hit && !rate[RATE_CONST])
			remaining <= remaining - 10'h001; // RULE22
	end

	// Single fault waits for the next generated bit
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
			shot_pend <= 1'b0;
		else if (shot_edge)
			shot_pend <= 1'b1; // RULE10
		else if (tx_step)
			shot_pend <= 1'b0;
	end

	assign fault  = shot_pend || auto_hit || ratio_hit;
	assign tx_bit = gen_bit ^ ctrl1[CTRL1_TXFLIP] ^ fault; // RULE1

	// Route the generated bit by direction
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			o_line_tx_pair       <= 1'b0;
			o_line_tx_valid      <= 1'b0;
			o_backplane_rx_out   <= 1'b0;
			o_backplane_rx_valid <= 1'b0;
		end
		else
		begin
			o_line_tx_valid      <= tx_step && !ifc[IFC_DIR]; // RULE19
			o_backplane_rx_valid <= tx_step && ifc[IFC_DIR]; // RULE18
			if (tx_step && !ifc[IFC_DIR])
				o_line_tx_pair <= tx_bit;
			if (tx_step && ifc[IFC_DIR])
				o_backplane_rx_out <= tx_bit;
		end
	end

	// Lock status pin
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
			o_sync_locked <= 1'b0;
		else
			o_sync_locked <= (sync_state == BTST_LOCK);
	end

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	a_latch_copy: assert property (latch_edge |=> // RULE6
		bit_count == $past(run_bits) && err_count == $past(run_errs) && run_bits == 32'h0)
		else $error("latched counts wrong");
	a_quota_load: assert property (commit_edge |=> remaining == $past(quota)) // RULE20
		else $error("quota not loaded");
	a_quota_dec: assert property ( // RULE22
		tx_step && ratio_hit && !rate[RATE_CONST] && !commit_edge
		|=> remaining == $past(remaining) - 10'h001)
		else $error("remaining not decremented");
	a_disabled_quiet: assert property (!enable && !latch_edge ##1 !enable |-> // RULE26
		!o_line_tx_valid && !o_backplane_rx_valid && $stable(run_bits))
		else $error("disabled tester active");
	a_dir_backplane: assert property ( // RULE18
		tx_step && ifc[IFC_DIR] |=> o_backplane_rx_valid && !o_line_tx_valid)
		else $error("backplane route wrong");
	a_dir_line: assert property ( // RULE19
		tx_step && !ifc[IFC_DIR] |=> o_line_tx_valid && o_backplane_rx_out == $past(o_backplane_rx_out))
		else $error("line route wrong");
	a_fbit_tx_skip: assert property ( // RULE17
		i_tx_bit_en && i_tx_fbit && !ifc[IFC_TXFBIT] |=> !o_line_tx_valid && !o_backplane_rx_valid)
		else $error("F-bit driven while framed");
	a_fbit_rx_skip: assert property ( // RULE15
		i_rx_fbit && !ifc[IFC_RXFBIT] && !latch_edge |=> $stable(run_bits))
		else $error("F-bit counted while framed");
	a_realign_drop: assert property (realign_edge |=> sync_state == BTST_HUNT ##1 !o_sync_locked) // RULE7
		else $error("lock kept after realign");
	a_shot_once: assert property (shot_pend && tx_step && !shot_edge |=> !shot_pend) // RULE10
		else $error("single fault repeated");
	a_tx_flip: assert property ( // RULE1
		tx_step && !ifc[IFC_DIR] |=> o_line_tx_pair == $past(gen_bit ^ fault ^ ctrl1[CTRL1_TXFLIP]))
		else $error("transmit inversion wrong");

	c_lock_gained: cover property (sync_state == BTST_HUNT ##1 sync_state == BTST_LOCK);
	c_latch_taken: cover property (latch_edge && run_bits != 32'h0);
	c_quota_empty: cover property (remaining == 10'h001 ##1 remaining == 10'h000);
endmodule : btst_top
`default_nettype wire

// >>> bench/btst_far.sv
// Far-side framer model: slot timing and loopback of the tester
`default_nettype none
module btst_far
(
	// Clock and control from the bench
	input  wire logic i_core_clk,
	input  wire logic i_run,
	input  wire logic i_flip,
	// Generated stream from the tester
	input  wire logic i_line_bit,
	input  wire logic i_line_v,
	input  wire logic i_bp_bit,
	input  wire logic i_bp_v,
	// Slot timing and looped-back stream
	output logic      o_tx_en,
	output logic      o_tx_fbit,
	output logic      o_rx_en,
	output logic      o_rx_bit,
	output logic      o_rx_fbit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       ph;
	logic       fpend;
	logic [2:0] slot;
	// Known state from time zero
	initial
	begin
		ph = 1'b0;
		slot = 3'd0;
		o_tx_en = 1'b0;
		o_rx_en = 1'b0;
		o_rx_bit = 1'b0;
		o_rx_fbit = 1'b0;
		fpend = 1'b0;
	end
	// Every eighth slot is the framing position
	assign o_tx_fbit = (slot == 3'd0);
	// One slot every other cycle; idle wire shows the inverse of the last bit
	always @(posedge i_core_clk)
	begin
		ph <= ~ph;
		o_tx_en <= i_run & ph;
		if (o_tx_en)
			slot <= slot + 3'd1;
		// Framing slot comes back even when the tester leaves it empty
		fpend <= o_tx_en & o_tx_fbit;
		o_rx_fbit <= fpend;
		o_rx_en <= i_line_v | i_bp_v | fpend;
		o_rx_bit <= (i_line_v | i_bp_v) ? ((i_line_v ? i_line_bit : i_bp_bit) ^ i_flip)
			: ~o_rx_bit;
	end
endmodule : btst_far
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench of the bit error-rate tester
`default_nettype none
module tb;
	import btst_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin errors++; \
		$display("ERROR %s exp %0h got %0h", n, e, s); end end
	logic        i_core_clk = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [9:0]  i_paddr = '0;
	logic [31:0] i_pwdata = '0, o_prdata, seed = 32'h0000_7e46, v, w;
	logic        o_pready, o_pslverr, tx_en, tx_fb, rx_en, rx_bit, rx_fb, lbit, lv, bbit, bvld;
	logic        locked, re, run = 0, flip = 0, grab = 0, bad, q[$];
	logic [7:0]  rq, base;
	int          errors = 0, checks_done = 0, exp_bits = 0, lvn = 0, bvn = 0, qn, len;
	bit          en_m = 0, fill_m = 0;

	always #2.5 i_core_clk = ~i_core_clk;
	btst_top dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_tx_bit_en(tx_en),
		.i_tx_fbit(tx_fb), .i_rx_bit_en(rx_en), .i_rx_fbit(rx_fb), .i_line_rx_pair(rx_bit),
		.i_backplane_tx_in(rx_bit), .o_line_tx_pair(lbit), .o_line_tx_valid(lv),
		.o_backplane_rx_out(bbit), .o_backplane_rx_valid(bvld), .o_sync_locked(locked));
	btst_far far (.i_core_clk(i_core_clk), .i_run(run), .i_flip(flip), .i_line_bit(lbit),
		.i_line_v(lv), .i_bp_bit(bbit), .i_bp_v(bvld), .o_tx_en(tx_en), .o_tx_fbit(tx_fb),
		.o_rx_en(rx_en), .o_rx_bit(rx_bit), .o_rx_fbit(rx_fb));

	// Model of taken slots and of pulses seen on each output
	always @(posedge i_core_clk)
	begin
		if (en_m && tx_en === 1'b1 && (tx_fb !== 1'b1 || fill_m))
			exp_bits++;
		if (lv === 1'b1)
			lvn++;
		if (bvld === 1'b1)
			bvn++;
		if (grab && lv === 1'b1)
			q.push_back(lbit);
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// One APB transfer, held until pready is sampled high
	task ap(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= {a, 2'b00};
		i_pwdata <= {24'h00_0000, d};
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		do @(posedge i_core_clk); while (o_pready !== 1'b1);
		rq = o_prdata[7:0];
		re = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : ap

	task rdn(input logic [7:0] a, input int n, output logic [31:0] r);
		r = '0;
		for (int i = 0; i < n; i++)
		begin
			ap(1'b0, 8'(a + i), 8'h00);
			r[8*i +: 8] = rq;
		end
	endtask : rdn

	// Raise then clear an edge bit of the first control register
	task kick(input logic [7:0] b);
		ap(1'b1, REG_CTRL1, base | b);
		ap(1'b1, REG_CTRL1, base);
	endtask : kick

	// One acquisition period: clear, traffic, latch and compare
	task period(input int n, input int ex_err);
		kick(8'h02);
		exp_bits = 0;
		lvn = 0;
		bvn = 0;
		run <= 1'b1;
		repeat (n) @(posedge i_core_clk);
		run <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		kick(8'h02);
		rdn(REG_BITS0, 4, v);
		`CHK("bit count", exp_bits, v)
		rdn(REG_ERR0, 3, v);
		if (ex_err >= 0) `CHK("error count", ex_err, v)
	endtask : period

	task test_done();
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (40000) @(posedge i_core_clk);
		errors++;
		test_done();
	end

	initial
	begin
		base = 8'h00;
		repeat (10) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		// Reset values, with one unmapped index
		for (int a = REG_ALT_RATE; a <= REG_REMAIN_HI; a++)
		begin
			ap(1'b0, a[7:0], 8'h00);
			`CHK("reset value", REG_RESET_VAL, rq)
			`CHK("slave error", a == 32'he2, re)
		end
		// Pattern bytes read back; count bytes are read-only
		v = xs();
		v[1:0] = 2'b01;
		v = {v[1:0], {5{v[5:0]}}};
		for (int i = 0; i < 4; i++)
			ap(1'b1, 8'(REG_REP0 + i), v[8*i +: 8]);
		rdn(REG_REP0, 4, w);
		`CHK("repeat value", v, w)
		ap(1'b1, REG_BITS0, 8'hff);
		rdn(REG_BITS0, 1, w);
		`CHK("read-only", 32'h0, w)
		// PRBS loopback toward the line reaches lock
		ap(1'b1, REG_IFC, 8'h01);
		en_m = 1;
		kick(8'h80);
		run <= 1'b1;
		for (int i = 0; i < 400 && locked !== 1'b1; i++)
			@(posedge i_core_clk);
		run <= 1'b0;
		`CHK("locked", 1'b1, locked)
		// Quota of faults at 1 in 16 plus one single fault
		qn = 1 + xs() % 4;
		ap(1'b1, REG_QUOTA_LO, qn[7:0]);
		ap(1'b1, REG_QUOTA_HI, 8'h00);
		ap(1'b1, REG_RATE, 8'h81);
		ap(1'b1, REG_RATE, 8'h01);
		rdn(REG_REMAIN_LO, 2, w);
		`CHK("remaining", qn, w)
		ap(1'b1, REG_CTRL2, 8'h10);
		ap(1'b1, REG_CTRL2, 8'h00);
		period(600, qn + 1);
		rdn(REG_REMAIN_LO, 2, w);
		`CHK("remaining", 32'h0, w)
		kick(8'h01);
		`CHK("lock dropped", 1'b0, locked)
		// Inverted transmit undone by the far side, then by the receive flip
		ap(1'b1, REG_IFC, 8'h49);
		fill_m = 1;
		for (int k = 0; k < 2; k++)
		begin
			base = k ? 8'h60 : 8'h40;
			flip <= (k == 0);
			kick(8'h01);
			period(400, 0);
			`CHK("locked", 1'b1, locked)
		end
		// Toward the backplane, then disabled
		ap(1'b1, REG_IFC, 8'h03);
		fill_m = 0;
		period(200, 0);
		`CHK("line pulses", 0, lvn)
		`CHK("backplane pulses", exp_bits, bvn)
		ap(1'b1, REG_IFC, 8'h02);
		en_m = 0;
		period(200, 0);
		`CHK("pulses when off", 0, lvn + bvn)
		// Repetitive pattern repeats at code plus 17
		len = 1 + 6 * (xs() % 3);
		ap(1'b1, REG_CTRL2, len[7:0]);
		ap(1'b1, REG_IFC, 8'h01);
		en_m = 1;
		base = {3'b000, PAT_REP, 2'b00};
		kick(8'h80);
		grab = 1;
		period(400, -1);
		bad = 0;
		for (int i = 0; i + len + 17 < q.size(); i++)
			if (q[i] !== q[i + len + 17] || q[i] !== q[i + 6])
				bad = 1;
		`CHK("repeat period", 1'b0, bad)
		// 55-octet pattern aligned by the kick bit, checker restarted
		base = {3'b000, PAT_DALY, 2'b00};
		ap(1'b1, REG_CTRL1, base);
		ap(1'b1, REG_IFC, 8'h11);
		ap(1'b1, REG_IFC, 8'h01);
		kick(8'h01);
		period(400, 0);
		`CHK("daly lock", 1'b1, locked)
		test_done();
	end
endmodule : tb
`default_nettype wire
